// file: hw/irq_option_lowpower.sv
// Overview of operation
// - Option register at C8h, write-only, no bit ops
// - Reset clears option register to zero
// - Bit 7 and bits 3-0 ignored
// - Bit 6 selects level or edge source 1
// - Bit 5 selects source 2 polarity
// - Polarity one rising, zero falling
// - Global enable gates maskable, not NMI
// - NMI without enable serviced, no wake
// - Vector 4: timer and converter events
// - Vector 3: three reload timer events
// - Vector 2: serial end of transmission; the code requests while serial_running_in is high
// - Ports A,B vector 1; port C vector 2
// - WAIT freezes core, clock keeps running
// - WAIT exit without stabilisation delay
// - Reset in WAIT or STOP resets normally
// - STOP only while watchdog disabled
// - STOP halts oscillator, awaits interrupt
// - STOP exit inserts stabilisation delay
// - Wake keeps oscillator selection
// - Main routine: service, then resume
// - NMI routine: resume, stay NMI mode
// - Normal routine: resume, stay IRQ mode
// - Skip WAIT/STOP when request pending
// - Watchdog active turns STOP into WAIT
`default_nettype none
module irq_option_lowpower #(
	// Stabilisation delay in core clock cycles.
	parameter int STAB_COUNT = irq_option_pkg::STAB_CYCLES,
	// Number of pins on each port.
	parameter int PORT_WIDTH = 8
) (
	// Clock, reset and enable.
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	// APB slave.
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Core data-space write port.
	input wire logic core_we_in,
	input wire logic core_bitop_in,
	input wire logic [7:0] core_addr_in,
	input wire logic [7:0] core_wdata_in,
	// Core instruction and mode status.
	input wire logic wait_exec_in,
	input wire logic stop_exec_in,
	input wire logic [1:0] core_mode_in,
	input wire logic watchdog_active_in,
	input wire logic src1_ack_in,
	input wire logic src2_ack_in,
	// External interrupt pins, asynchronous.
	input wire logic nmi_pin_in,
	input wire logic src1_pin_in,
	input wire logic src2_pin_in,
	// Peripheral events, same clock.
	input wire logic timer_zero_flag_in,
	input wire logic conv_end_in,
	input wire logic reload_overflow_flag_in,
	input wire logic reload_compare_flag_in,
	input wire logic reload_edge_flag_in,
	input wire logic serial_running_in,
	input wire logic [PORT_WIDTH-1:0] port_a_irq_in,
	input wire logic [PORT_WIDTH-1:0] port_b_irq_in,
	input wire logic [PORT_WIDTH-1:0] port_c_irq_in,
	// Requests and power control toward the core.
	output logic nmi_req_out,
	output logic [4:1] vector_req_out,
	output logic core_freeze_out,
	output logic osc_halt_out,
	output logic wake_out,
	output logic [1:0] resume_mode_out
);
	import irq_option_pkg::*;

	// ----------------------------------------------------------------------
	// Input synchronisers.
	// ----------------------------------------------------------------------
	// Pins pass two flops; stage one feeds only stage two.
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] next_sync1;
	logic [2:0] next_sync2;
	// Previous synchronised levels for edge detection.
	logic [2:0] pin_prev;
	logic [2:0] next_pin_prev;

	// Combinational next values of the synchronisers.
	always_comb begin
		next_sync1 = {src2_pin_in, src1_pin_in, nmi_pin_in};
		next_sync2 = sync1;
		next_pin_prev = sync2;
	end

	// Register the synchronisers.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			sync1 <= 3'h7;
			sync2 <= 3'h7;
			pin_prev <= 3'h7;
		end else if (ce_in) begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
			pin_prev <= next_pin_prev;
		end
	end

	// ----------------------------------------------------------------------
	// Registers.
	// ----------------------------------------------------------------------
	logic [7:0] interrupt_option; // Stores only the used bits.
	logic [7:0] next_interrupt_option;
	logic [7:0] periph_mask; // Peripheral enable bits.
	logic [7:0] next_periph_mask;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic apb_setup;
	logic apb_hit_opt;
	logic apb_hit_mask;
	logic apb_hit_pwr;
	logic apb_access; // Access phase with the answer standing.
	power_state_t state; // Current power state, read back as status.
	logic [1:0] resume_mode; // Core mode saved when sleep began.

	// Decode a byte address against one register offset.
	function automatic logic addr_hit(input logic [11:0] a,
		input logic [11:0] off);
		addr_hit = (a[11:2] == off[11:2]);
	endfunction : addr_hit

	// Register write and APB answer logic.
	always_comb begin
		next_interrupt_option = interrupt_option;
		next_periph_mask = periph_mask;
		next_prdata = 32'h0000_0000;
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		// The answer comes one cycle after setup, in the access phase.
		apb_setup = psel_in && !penable_in;
		apb_access = psel_in && penable_in && pready_out;
		apb_hit_opt = addr_hit(paddr_in, APB_OPTION_OFFSET);
		apb_hit_mask = addr_hit(paddr_in, APB_MASK_OFFSET);
		apb_hit_pwr = addr_hit(paddr_in, APB_POWER_OFFSET);
		if (core_we_in && !core_bitop_in &&
			core_addr_in == INTERRUPT_OPTION_ADDR) begin
			next_interrupt_option = core_wdata_in & OPTION_USED_MASK;
		end
		if (apb_setup) begin
			next_pready = 1'b1;
			if (pwrite_in) begin
				if (!apb_hit_opt && !apb_hit_mask) begin
					// Status is read-only; other addresses error.
					next_pslverr = 1'b1;
				end
			end else begin
				if (apb_hit_mask) begin
					next_prdata = {24'h00_0000, periph_mask};
				end else if (apb_hit_pwr) begin
					next_prdata = {24'h00_0000, state, 2'h0, resume_mode};
				end else if (apb_hit_opt) begin
					next_prdata = 32'h0000_0000;
				end else begin
					next_pslverr = 1'b1;
				end
			end
		end
		// Writes land at the edge where the master samples pready high.
		if (apb_access && pwrite_in) begin
			if (apb_hit_opt && pstrb_in[0]) begin
				next_interrupt_option = pwdata_in[7:0] & OPTION_USED_MASK;
			end else if (apb_hit_mask && pstrb_in[0]) begin
				next_periph_mask = pwdata_in[7:0];
			end
		end
	end

	// Register file registers and APB outputs.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			interrupt_option <= OPTION_RESET;
			periph_mask <= MASK_RESET;
			prdata_out <= 32'h0000_0000;
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
		end else if (ce_in) begin
			interrupt_option <= next_interrupt_option;
			periph_mask <= next_periph_mask;
			prdata_out <= next_prdata;
			pready_out <= next_pready;
			pslverr_out <= next_pslverr;
		end
	end

	// ----------------------------------------------------------------------
	// Request logic.
	// ----------------------------------------------------------------------
	logic global_irq_enable;
	logic src1_level_select;
	logic src2_polarity_select;
	logic nmi_latch;
	logic src1_latch;
	logic src2_latch;
	logic next_nmi_latch;
	logic next_src1_latch;
	logic next_src2_latch;
	logic [4:1] next_vector_req;
	logic next_nmi_req;
	logic any_req;
	logic src1_prev; // Source 1 line level one cycle back.
	logic next_src1_prev;

	assign global_irq_enable = interrupt_option[GLOBAL_ENABLE_BIT];
	assign src1_level_select = interrupt_option[SRC1_LEVEL_BIT];
	assign src2_polarity_select = interrupt_option[SRC2_POLARITY_BIT];

	// Latch edges and route peripheral events onto vectors.
	always_comb begin
		logic src1_raw;
		logic src2_raw;
		logic src2_edge;
		src1_raw = 1'b0;
		src2_raw = 1'b0;
		src2_edge = 1'b0;
		// Port pins share the pin lines of sources 1 and 2.
		// ports A,B to 1, C to 2
		src1_raw = !sync2[1] || (|port_a_irq_in) || (|port_b_irq_in);
		src2_raw = (|port_c_irq_in);
		src2_edge = src2_polarity_select ? (sync2[2] && !pin_prev[2]) :
			(!sync2[2] && pin_prev[2]);
		// A new edge wins over the routine start in the same cycle.
		next_nmi_latch = (pin_prev[0] && !sync2[0]) ||
			(nmi_latch && core_mode_in != CORE_NMI);
		next_src1_latch = (!src1_level_select && src1_raw &&
			!src1_prev) || (src1_latch && !src1_ack_in);
		next_src2_latch = src2_edge || src2_raw ||
			(src2_latch && !src2_ack_in);
		next_vector_req[1] = global_irq_enable &&
			(src1_level_select ? src1_raw : src1_latch);
		next_vector_req[2] = global_irq_enable && (src2_latch ||
			(serial_running_in && periph_mask[SERIAL_EN_BIT]));
		next_vector_req[3] = global_irq_enable &&
			((reload_overflow_flag_in && periph_mask[RLD_OVERFLOW_EN_BIT]) ||
			(reload_compare_flag_in && periph_mask[RLD_CMP_EN_BIT]) ||
			(reload_edge_flag_in && periph_mask[RLD_EDGE_EN_BIT]));
		next_vector_req[4] = global_irq_enable &&
			((timer_zero_flag_in && periph_mask[TIMER_EN_BIT]) ||
			(conv_end_in && periph_mask[CONV_EN_BIT]));
		next_nmi_req = nmi_latch;
	end

	assign next_src1_prev = !sync2[1] || (|port_a_irq_in) ||
		(|port_b_irq_in);

	// Register the request state.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			nmi_latch <= 1'b0;
			src1_latch <= 1'b0;
			src2_latch <= 1'b0;
			src1_prev <= 1'b0;
			nmi_req_out <= 1'b0;
			vector_req_out <= 4'h0;
		end else if (ce_in) begin
			nmi_latch <= next_nmi_latch;
			src1_latch <= next_src1_latch;
			src2_latch <= next_src2_latch;
			src1_prev <= next_src1_prev;
			nmi_req_out <= next_nmi_req;
			vector_req_out <= next_vector_req;
		end
	end

	assign any_req = global_irq_enable &&
		(nmi_req_out || (|vector_req_out));

	// ----------------------------------------------------------------------
	// Power state machine.
	// ----------------------------------------------------------------------
	power_state_t next_state;
	logic [31:0] stab_cnt;
	logic [31:0] next_stab_cnt;
	logic [1:0] next_resume_mode;
	logic next_freeze;
	logic next_halt;
	logic next_wake;

	// Entry, exit and stabilisation sequencing.
	always_comb begin
		next_state = state;
		next_stab_cnt = stab_cnt;
		next_resume_mode = resume_mode;
		next_wake = 1'b0;
		case (state)
			PWR_RUN: begin
				if ((wait_exec_in || stop_exec_in) && !any_req) begin
					next_resume_mode = core_mode_in;
					if (stop_exec_in && !watchdog_active_in) begin
						next_state = PWR_STOP;
					end else begin
						next_state = PWR_WAIT;
					end
				end
			end
			PWR_WAIT: begin
				if (any_req) begin
					next_state = PWR_RUN;
					next_wake = 1'b1;
				end
			end
			PWR_STOP: begin
				if (any_req) begin
					next_state = PWR_STAB;
					next_stab_cnt = 32'(STAB_COUNT);
				end
			end
			PWR_STAB: begin
				if (stab_cnt <= 32'h0000_0001) begin
					next_state = PWR_RUN;
					next_wake = 1'b1;
				end else begin
					next_stab_cnt = stab_cnt - 32'h0000_0001;
				end
			end
			default: begin
				next_state = PWR_RUN;
			end
		endcase
		next_freeze = (next_state != PWR_RUN);
		next_halt = (next_state == PWR_STOP);
	end

	// Register power state. reset returns to run.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state <= PWR_RUN;
			stab_cnt <= 32'h0000_0000;
			resume_mode <= CORE_NORMAL;
			core_freeze_out <= 1'b0;
			osc_halt_out <= 1'b0;
			wake_out <= 1'b0;
			resume_mode_out <= CORE_NORMAL;
		end else if (ce_in) begin
			state <= next_state;
			stab_cnt <= next_stab_cnt;
			resume_mode <= next_resume_mode;
			core_freeze_out <= next_freeze;
			osc_halt_out <= next_halt;
			wake_out <= next_wake;
			resume_mode_out <= next_resume_mode;
		end
	end
endmodule : irq_option_lowpower
`default_nettype wire

// file: hw/irq_option_pkg.sv
`default_nettype none
package irq_option_pkg;
	// ----------------------------------------------------------------------
	// Register map.
	// ----------------------------------------------------------------------
	// Data-space address of the interrupt option register.
	localparam logic [7:0] INTERRUPT_OPTION_ADDR = 8'hC8;
	// Byte address of the option register on APB.
	localparam logic [11:0] APB_OPTION_OFFSET = 12'h0C8;
	// Byte address of the peripheral mask register.
	localparam logic [11:0] APB_MASK_OFFSET = 12'h100;
	// Byte address of the read-only low-power status register.
	localparam logic [11:0] APB_POWER_OFFSET = 12'h104;
	// Reset value of the option register.
	localparam logic [7:0] OPTION_RESET = 8'h00;
	// Reset value of the peripheral mask register.
	localparam logic [7:0] MASK_RESET = 8'h00;

	// ----------------------------------------------------------------------
	// Option register fields.
	// ----------------------------------------------------------------------
	localparam int SRC1_LEVEL_BIT = 6;
	localparam int SRC2_POLARITY_BIT = 5;
	localparam int GLOBAL_ENABLE_BIT = 4;
	// Bits that have an effect; the rest are ignored.
	localparam logic [7:0] OPTION_USED_MASK = 8'h70;

	// ----------------------------------------------------------------------
	// Peripheral mask register fields.
	// ----------------------------------------------------------------------
	localparam int TIMER_EN_BIT = 0;
	localparam int CONV_EN_BIT = 1;
	localparam int RLD_OVERFLOW_EN_BIT = 2;
	localparam int RLD_CMP_EN_BIT = 3;
	localparam int RLD_EDGE_EN_BIT = 4;
	localparam int SERIAL_EN_BIT = 5;

	// ----------------------------------------------------------------------
	// Timing.
	// ----------------------------------------------------------------------
	// Oscillator stabilisation time after a STOP wake-up, in microseconds.
	localparam int STAB_TIME_US = 256;
	localparam int CLK_MHZ = 20;
	localparam int STAB_CYCLES = STAB_TIME_US * CLK_MHZ;

	// ----------------------------------------------------------------------
	// Power states, one-hot.
	// ----------------------------------------------------------------------
	typedef enum logic [3:0] {
		PWR_RUN = 4'h1,
		PWR_WAIT = 4'h2,
		PWR_STOP = 4'h4,
		PWR_STAB = 4'h8
	} power_state_t;

	// Core mode before entering a low-power state.
	localparam logic [1:0] CORE_NORMAL = 2'h0;
	localparam logic [1:0] CORE_IRQ = 2'h1;
	localparam logic [1:0] CORE_NMI = 2'h2;
endpackage : irq_option_pkg
`default_nettype wire

// file: tb/irq_option_monitor.sv
`default_nettype none
module irq_option_monitor (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic srst_in,
	// Bus and core inputs.
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic core_we_in,
	input wire logic core_bitop_in,
	input wire logic [7:0] core_addr_in,
	input wire logic [7:0] core_wdata_in,
	input wire logic wait_exec_in,
	input wire logic stop_exec_in,
	input wire logic watchdog_active_in,
	// Outputs under watch.
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic [4:1] vector_req_out,
	input wire logic core_freeze_out,
	input wire logic osc_halt_out,
	input wire logic wake_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import irq_option_pkg::*;
	// Shadow of the global enable, rebuilt from both write paths.
	logic enable_shadow;
	logic next_enable_shadow;
	// The option register cannot be read, so the enable is tracked here.
	always_comb begin
		next_enable_shadow = enable_shadow;
		if (core_we_in && !core_bitop_in &&
			core_addr_in == INTERRUPT_OPTION_ADDR) begin
			next_enable_shadow = core_wdata_in[GLOBAL_ENABLE_BIT];
		end
		if (pready_out && pwrite_in && paddr_in == APB_OPTION_OFFSET) begin
			next_enable_shadow = pwdata_in[GLOBAL_ENABLE_BIT];
		end
	end
	// The shadow clears with the block.
	always_ff @(posedge clk_in) begin
		enable_shadow <= srst_in ? 1'b0 : next_enable_shadow;
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	setup_answer_a: assert property (psel_in && !penable_in |=> pready_out)
		else $error("No bus answer after setup.");
	option_hidden_a: assert property (
		pready_out && !pwrite_in && paddr_in == APB_OPTION_OFFSET
		|-> prdata_out == 32'h0) else $error("Option register read back.");
	wake_enable_a: assert property (wake_out |-> enable_shadow)
		else $error("Wake without global enable.");
	mask_enable_a: assert property (
		!enable_shadow [*3] |-> vector_req_out == 4'h0)
		else $error("Request not gated.");
	stop_freeze_a: assert property (osc_halt_out |-> core_freeze_out)
		else $error("Oscillator halted while core runs.");
	dog_stop_a: assert property (
		$rose(osc_halt_out) |-> $past(stop_exec_in && !watchdog_active_in))
		else $error("Oscillator halted without a clean stop.");
	skip_pending_a: assert property (
		wait_exec_in && !core_freeze_out && vector_req_out != 4'h0
		|=> !core_freeze_out) else $error("Sleep with request pending.");
	reset_clear_a: assert property (disable iff (1'b0)
		srst_in |=> !core_freeze_out && !osc_halt_out && !wake_out)
		else $error("Power state survived reset.");
endmodule : irq_option_monitor
bind irq_option_lowpower irq_option_monitor monitor (.clk_in(clk_in),
	.srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
	.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
	.core_we_in(core_we_in), .core_bitop_in(core_bitop_in),
	.core_addr_in(core_addr_in), .core_wdata_in(core_wdata_in),
	.wait_exec_in(wait_exec_in), .stop_exec_in(stop_exec_in),
	.watchdog_active_in(watchdog_active_in), .prdata_out(prdata_out),
	.pready_out(pready_out), .vector_req_out(vector_req_out),
	.core_freeze_out(core_freeze_out), .osc_halt_out(osc_halt_out),
	.wake_out(wake_out));
`default_nettype wire

// file: tb/core_partner.sv
`default_nettype none
module core_partner (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic srst_in,
	// Requests from the block and pacing from the bench.
	input wire logic [4:1] vector_req_in,
	input wire logic freeze_in,
	input wire logic ack_en_in,
	input wire logic [3:0] delay_in,
	// Routine starts back to the block.
	output logic src1_ack_out,
	output logic src2_ack_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// Cycles spent before a vector is taken.
	int cnt = 0;
	initial {src1_ack_out, src2_ack_out} = 2'b00;
	// A frozen core fetches nothing, so no routine starts in sleep.
	always @(posedge clk_in) begin
		if (srst_in || !ack_en_in || freeze_in ||
			vector_req_in[2:1] == 2'b00) begin
			cnt <= 0;
			src1_ack_out <= 1'b0;
			src2_ack_out <= 1'b0;
		end else if (cnt < int'(delay_in)) begin
			cnt <= cnt + 1;
			src1_ack_out <= 1'b0;
			src2_ack_out <= 1'b0;
		end else begin
			src1_ack_out <= vector_req_in[1];
			src2_ack_out <= !vector_req_in[1];
			cnt <= -2;
		end
	end
endmodule : core_partner
`default_nettype wire

// file: tb/interrupt_option_and_low_power_test.sv
`default_nettype none
`define CHK(what, exp, got) begin \
	n_checks++; \
	if ((got) !== (exp)) begin \
		errors++; \
		$display("CHECK FAILED %s exp %0h got %0h", what, exp, got); \
	end \
end
module interrupt_option_and_low_power_test;
	timeunit 1ns;
	timeprecision 1ns;
	import irq_option_pkg::*;
	// A short stabilisation count keeps the run brief.
	localparam int STAB = 8;
	logic clk_in = 1'b0;
	logic srst_in, ce_in, psel_in, penable_in, pwrite_in, core_we_in;
	logic core_bitop_in, wait_exec_in, stop_exec_in, watchdog_active_in;
	logic src1_ack_in, src2_ack_in, nmi_pin_in, src1_pin_in, src2_pin_in;
	logic timer_zero_flag_in, conv_end_in, reload_overflow_flag_in;
	logic reload_compare_flag_in, reload_edge_flag_in, serial_running_in;
	logic pready_out, pslverr_out, nmi_req_out, core_freeze_out;
	logic osc_halt_out, wake_out, ack_en;
	logic [1:0] core_mode_in, resume_mode_out;
	logic [3:0] pstrb_in, dly;
	logic [4:1] vector_req_out;
	logic [5:0] ev;
	logic [7:0] core_addr_in, core_wdata_in;
	logic [7:0] port_a_irq_in, port_b_irq_in, port_c_irq_in;
	logic [11:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, seed;
	int errors, n_checks;
	// Vector expected for each peripheral event, in mask-bit order.
	logic [4:1] route[$] = '{4'h8, 4'h8, 4'h4, 4'h4, 4'h4, 4'h2};
	assign {serial_running_in, reload_edge_flag_in, reload_compare_flag_in,
		reload_overflow_flag_in, conv_end_in, timer_zero_flag_in} = ev;
	always #25 clk_in = ~clk_in;
	irq_option_lowpower #(.STAB_COUNT(STAB)) dut (.clk_in(clk_in),
		.srst_in(srst_in), .ce_in(ce_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
		.prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .core_we_in(core_we_in),
		.core_bitop_in(core_bitop_in), .core_addr_in(core_addr_in),
		.core_wdata_in(core_wdata_in), .wait_exec_in(wait_exec_in),
		.stop_exec_in(stop_exec_in), .core_mode_in(core_mode_in),
		.watchdog_active_in(watchdog_active_in),
		.src1_ack_in(src1_ack_in), .src2_ack_in(src2_ack_in),
		.nmi_pin_in(nmi_pin_in), .src1_pin_in(src1_pin_in),
		.src2_pin_in(src2_pin_in), .timer_zero_flag_in(timer_zero_flag_in),
		.conv_end_in(conv_end_in),
		.reload_overflow_flag_in(reload_overflow_flag_in),
		.reload_compare_flag_in(reload_compare_flag_in),
		.reload_edge_flag_in(reload_edge_flag_in),
		.serial_running_in(serial_running_in),
		.port_a_irq_in(port_a_irq_in), .port_b_irq_in(port_b_irq_in),
		.port_c_irq_in(port_c_irq_in), .nmi_req_out(nmi_req_out),
		.vector_req_out(vector_req_out),
		.core_freeze_out(core_freeze_out), .osc_halt_out(osc_halt_out),
		.wake_out(wake_out), .resume_mode_out(resume_mode_out));
	core_partner partner (.clk_in(clk_in), .srst_in(srst_in),
		.vector_req_in(vector_req_out), .freeze_in(core_freeze_out),
		.ack_en_in(ack_en), .delay_in(dly), .src1_ack_out(src1_ack_in),
		.src2_ack_out(src2_ack_in));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic tally_and_finish();
		if (errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : tally_and_finish
	// One bus transfer; the request is held until pready is sampled.
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, input logic xe);
		psel_in <= 1'b1;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do begin
			@(posedge clk_in);
		end while (pready_out !== 1'b1);
		`CHK("pslverr", xe, pslverr_out)
		if (!wr && !xe) `CHK("prdata", d, prdata_out)
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge clk_in);
	endtask : apb
	// Waits out the synchroniser, then for the expected requests.
	task automatic vcheck(input logic [4:1] x, input logic a);
		int n;
		dly <= 4'(rnd()) & 4'h7;
		ack_en <= a;
		repeat (6) @(posedge clk_in);
		for (n = 0; n < 10 && vector_req_out !== x; n++) @(posedge clk_in);
		`CHK("vector", x, vector_req_out)
		ack_en <= 1'b0;
	endtask : vcheck
	task automatic cwr(input logic b, input logic [7:0] d);
		core_we_in <= 1'b1;
		core_bitop_in <= b;
		core_addr_in <= INTERRUPT_OPTION_ADDR;
		core_wdata_in <= d;
		@(posedge clk_in);
		core_we_in <= 1'b0;
		@(posedge clk_in);
	endtask : cwr
	// Sleep, then wake through an edge on source 1.
	task automatic nap(input logic stp, input logic dog, input logic [1:0] m);
		int n;
		n = 0;
		watchdog_active_in <= dog;
		core_mode_in <= m;
		wait_exec_in <= !stp;
		stop_exec_in <= stp;
		@(posedge clk_in);
		wait_exec_in <= 1'b0;
		stop_exec_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		`CHK("freeze", 1'b1, core_freeze_out)
		`CHK("halt", stp & !dog, osc_halt_out)
		`CHK("mode", m, resume_mode_out)
		src1_pin_in <= 1'b0;
		for (n = 0; n < 40 && wake_out !== 1'b1; n++) @(posedge clk_in);
		`CHK("span", 1'b1, stp && !dog ? n > STAB : n < 10)
		src1_pin_in <= 1'b1;
		vcheck(4'h0, 1'b1);
	endtask : nap
	initial begin
		{psel_in, penable_in, pwrite_in, core_we_in, core_bitop_in} = '0;
		{wait_exec_in, stop_exec_in, watchdog_active_in, ack_en, ev} = '0;
		{core_mode_in, dly, paddr_in, pwdata_in, core_addr_in} = '0;
		{core_wdata_in, port_a_irq_in, port_b_irq_in, port_c_irq_in} = '0;
		{nmi_pin_in, src1_pin_in, src2_pin_in, ce_in, srst_in} = 5'h1F;
		pstrb_in = 4'hF;
		seed = 32'h0000D939;
		repeat (3) @(posedge clk_in);
		srst_in <= 1'b0;
		@(posedge clk_in);
		apb(1'b0, APB_POWER_OFFSET, 32'h10, 1'b0);
		apb(1'b0, APB_MASK_OFFSET, 32'h0, 1'b0);
		apb(1'b1, APB_OPTION_OFFSET, rnd() & 32'hFFFFFF8F | 32'h8F, 1'b0);
		apb(1'b0, APB_OPTION_OFFSET, 32'h0, 1'b0);
		apb(1'b1, APB_POWER_OFFSET, 32'hFF, 1'b1);
		apb(1'b0, 12'h200, 32'h0, 1'b1);
		apb(1'b1, APB_MASK_OFFSET, 32'h3F, 1'b0);
		ev <= 6'h3F;
		vcheck(4'h0, 1'b0);
		cwr(1'b1, 8'h10);
		vcheck(4'h0, 1'b0);
		cwr(1'b0, 8'h10);
		vcheck(4'hE, 1'b0);
		for (int i = 0; i < 6; i++) begin
			ev <= 6'h01 << i;
			apb(1'b1, APB_MASK_OFFSET, 32'h3F ^ (32'h1 << i), 1'b0);
			vcheck(4'h0, 1'b0);
			apb(1'b1, APB_MASK_OFFSET, 32'h1 << i, 1'b0);
			vcheck(route[i], 1'b0);
		end
		// With the clock enable low the serial request must stand frozen.
		ce_in <= 1'b0;
		ev <= 6'h00;
		repeat (4) @(posedge clk_in);
		`CHK("frozen", 4'h2, vector_req_out)
		ce_in <= 1'b1;
		vcheck(4'h0, 1'b0);
		port_a_irq_in <= 8'(rnd()) | 8'h01;
		vcheck(4'h1, 1'b0);
		port_a_irq_in <= 8'h00;
		vcheck(4'h0, 1'b1);
		port_b_irq_in <= 8'(rnd()) | 8'h80;
		vcheck(4'h1, 1'b0);
		port_b_irq_in <= 8'h00;
		vcheck(4'h0, 1'b1);
		port_c_irq_in <= 8'h04;
		vcheck(4'h2, 1'b0);
		port_c_irq_in <= 8'h00;
		vcheck(4'h0, 1'b1);
		src1_pin_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		src1_pin_in <= 1'b1;
		vcheck(4'h1, 1'b0);
		vcheck(4'h0, 1'b1);
		cwr(1'b0, 8'h50);
		src1_pin_in <= 1'b0;
		vcheck(4'h1, 1'b0);
		src1_pin_in <= 1'b1;
		vcheck(4'h0, 1'b0);
		for (int p = 0; p < 2; p++) begin
			cwr(1'b0, p ? 8'h30 : 8'h10);
			src2_pin_in <= 1'b0;
			vcheck(p ? 4'h0 : 4'h2, 1'b0);
			src2_pin_in <= 1'b1;
			vcheck(4'h2, 1'b0);
			vcheck(4'h0, 1'b1);
		end
		cwr(1'b0, 8'h10);
		nap(1'b0, 1'b0, CORE_NORMAL);
		nap(1'b1, 1'b0, CORE_IRQ);
		nap(1'b1, 1'b1, CORE_NMI);
		core_mode_in <= CORE_NORMAL;
		port_a_irq_in <= 8'h01;
		vcheck(4'h1, 1'b0);
		wait_exec_in <= 1'b1;
		@(posedge clk_in);
		wait_exec_in <= 1'b0;
		port_a_irq_in <= 8'h00;
		repeat (2) @(posedge clk_in);
		`CHK("skip", 1'b0, core_freeze_out)
		vcheck(4'h0, 1'b1);
		wait_exec_in <= 1'b1;
		@(posedge clk_in);
		wait_exec_in <= 1'b0;
		nmi_pin_in <= 1'b0;
		@(posedge clk_in);
		`CHK("nap", 1'b1, core_freeze_out)
		repeat (7) @(posedge clk_in);
		`CHK("nmi wake", 1'b0, core_freeze_out)
		core_mode_in <= CORE_NMI;
		nmi_pin_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		`CHK("nmi clear", 1'b0, nmi_req_out)
		core_mode_in <= CORE_NORMAL;
		cwr(1'b0, 8'h00);
		wait_exec_in <= 1'b1;
		@(posedge clk_in);
		wait_exec_in <= 1'b0;
		nmi_pin_in <= 1'b0;
		repeat (8) @(posedge clk_in);
		`CHK("nmi", 1'b1, nmi_req_out)
		`CHK("asleep", 1'b1, core_freeze_out)
		srst_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		srst_in <= 1'b0;
		nmi_pin_in <= 1'b1;
		@(posedge clk_in);
		apb(1'b0, APB_POWER_OFFSET, 32'h10, 1'b0);
		tally_and_finish();
	end
	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (6000) @(posedge clk_in);
		errors++;
		tally_and_finish();
	end
endmodule : interrupt_option_and_low_power_test
`default_nettype wire
